// file: design/iwd_decoder.sv
/*
 * iwd_decoder: splits fetched 14-bit words into class and operand fields,
 * picks the result destination and times one- or two-cycle execution.
 * assumes: program memory holds INSTR_WORD stable across the phase-0 MCLK
 * edge that takes it; the execute unit reports taken tests on SKIP_TAKEN.
 */
// Function
// RL1: accept 14-bit words, opcode plus operands
// RL2: classify byte, bit, literal/control
// RL3: byte class yields file address, destination
// RL4: dest 0 to working, 1 to file
// RL5: file address is seven bits, 0x00-0x7F
// RL6: bit class yields bit number and file
// RL7: literal operand eight or eleven bits
// RL8: don't-care bits never affect decoding
// RL9: one cycle; branch or true test two
// RL10: instruction cycle equals four oscillator periods
// RL11: port read-modify-write uses pin levels
// RL12: timer count write clears assigned prescaler; bit-class writes to the timer do not clear it here
// RL13: second cycle discards prefetch, no updates
`timescale 1ns/1ps
module iwd_decoder
    import iwd_pkg::*;
#(
    parameter logic [6:0] TIMER_ADDR = 7'h01,
    parameter logic [6:0] PORT_LO    = 7'h05,
    parameter logic [6:0] PORT_HI    = 7'h09
)(
    input  wire logic                   MCLK,
    input  wire logic                   SRST,
    input  wire logic [IWD_WORD_W-1:0]  INSTR_WORD,
    input  wire logic                   SKIP_TAKEN,
    input  wire logic                   PRESCALER_ON_TIMER,
    output logic [1:0]                  INSTR_CLASS,
    output logic [IWD_FADDR_W-1:0]      FILE_ADDR,
    output logic                        DEST_FREG,
    output logic                        WREG_WE,
    output logic                        FREG_WE,
    output logic [IWD_BIT_W-1:0]        BIT_NUM,
    output logic [IWD_LIT11_W-1:0]      LITERAL,
    output logic                        LIT_WIDE,
    output logic                        READ_PINS,
    output logic                        PRESCALER_CLR,
    output logic                        DUMMY_CYCLE,
    output logic                        FLUSH_PREFETCH,
    output logic [1:0]                  PHASE
);
    logic [1:0]             phase;
    logic                   cycle_end;
    logic [IWD_WORD_W-1:0]  word_q;
    logic                   dummy_q;
    logic                   dummy_d;
    iwd_class_e             cls;
    logic [1:0]             top;
    logic [3:0]             byte_op;
    logic [1:0]             bit_op;
    logic                   is_byte;
    logic                   is_bit;
    logic                   writes_f;
    logic                   writes_w;
    logic                   flow_change;
    logic                   is_port;
    logic                   start;
    logic [1:0]             cls_q;
    logic [6:0]             faddr_q;
    logic                   dest_q;
    logic                   wwe_q;
    logic                   fwe_q;
    logic [2:0]             bit_q;
    logic [10:0]            lit_q;
    logic                   wide_q;
    logic                   pins_q;
    logic                   pclr_q;
    logic                   flush_q;
    logic [1:0]             phase_q;

    iwd_phase_seq u_seq (
        .clk       (MCLK),
        .srst      (SRST),
        .phase     (phase),
        .cycle_end (cycle_end)
    );

    // class from the top bits alone, so x bits inside fields never matter
    function automatic iwd_class_e class_of(input logic [1:0] t);
        case (t)
            IWD_CLS_BYTE: class_of = IWD_CLASS_BYTE;
            IWD_CLS_BIT:  class_of = IWD_CLASS_BIT;
            default:      class_of = IWD_CLASS_LITCTL;
        endcase
    endfunction

    // word captured at the start of each instruction cycle that is not a dummy cycle
    assign start    = (phase == IWD_PHASE_RST);
    assign top      = word_q[IWD_WORD_W-1:IWD_CLASS_LSB]; // RL1
    assign cls      = class_of(top); // RL2
    assign is_byte  = (cls == IWD_CLASS_BYTE);
    assign is_bit   = (cls == IWD_CLASS_BIT);
    assign byte_op  = word_q[IWD_CLASS_LSB-1:IWD_BYTEOP_LSB];
    assign bit_op   = word_q[IWD_CLASS_LSB-1:IWD_BOP_LSB];
    // movwf/clrf have d set; the nop/return group has d clear and writes nothing
    assign writes_f = is_byte && word_q[IWD_DEST_POS] && !dummy_q; // RL4 RL13
    assign writes_w = is_byte && !word_q[IWD_DEST_POS] && (byte_op != IWD_OP_MOVWF)
                      && !dummy_q; // RL4 RL8 RL13
    // jumps, return, retfie and literal-class retlw change program flow
    assign flow_change = (top == IWD_CLS_JUMP) || (word_q == IWD_W_RETURN)
                      || (word_q == IWD_W_RETFIE)
                      || ((top == IWD_CLS_LIT) && (word_q[11:8] == IWD_LIT_RETLW)); // RL9
    assign is_port  = (word_q[6:0] >= PORT_LO) && (word_q[6:0] <= PORT_HI);
    // a skip test truth arrives from execute; jumps always take two cycles
    assign dummy_d  = !dummy_q && (flow_change || SKIP_TAKEN); // RL9

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            word_q  <= IWD_WORD_RST;
            dummy_q <= 1'b0;
        end else begin
            if (start && !dummy_q) begin
                word_q <= INSTR_WORD; // RL1
            end
            if (cycle_end) begin
                dummy_q <= dummy_d; // RL9 RL13
            end
        end
    end

    // all outputs registered
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            cls_q   <= 2'h0;
            faddr_q <= 7'h00;
            dest_q  <= IWD_DEST_WREG;
            wwe_q   <= 1'b0;
            fwe_q   <= 1'b0;
            bit_q   <= 3'h0;
            lit_q   <= 11'h000;
            wide_q  <= 1'b0;
            pins_q  <= 1'b0;
            pclr_q  <= 1'b0;
            flush_q <= 1'b0;
            phase_q <= IWD_PHASE_RST;
        end else begin
            cls_q   <= 2'(cls); // RL2
            faddr_q <= word_q[IWD_FADDR_W-1:0]; // RL3 RL5
            dest_q  <= word_q[IWD_DEST_POS]; // RL3 RL4
            wwe_q   <= writes_w && cycle_end; // RL4
            fwe_q   <= (writes_f || (is_bit && !bit_op[1] && !dummy_q)) && cycle_end; // RL4 RL6
            bit_q   <= word_q[IWD_BIT_LSB+IWD_BIT_W-1:IWD_BIT_LSB]; // RL6
            wide_q  <= (top == IWD_CLS_JUMP); // RL7
            lit_q   <= (top == IWD_CLS_JUMP) ? word_q[10:0]
                       : {3'h0, word_q[IWD_LIT8_W-1:0]}; // RL7 RL8
            pins_q  <= (is_byte || is_bit) && is_port && !dummy_q; // RL11
            pclr_q  <= writes_f && (word_q[6:0] == TIMER_ADDR) && PRESCALER_ON_TIMER
                       && cycle_end; // RL12
            flush_q <= dummy_q; // RL13
            phase_q <= phase; // RL10
        end
    end

    assign INSTR_CLASS    = cls_q;
    assign FILE_ADDR      = faddr_q;
    assign DEST_FREG      = dest_q;
    assign WREG_WE        = wwe_q;
    assign FREG_WE        = fwe_q;
    assign BIT_NUM        = bit_q;
    assign LITERAL        = lit_q;
    assign LIT_WIDE       = wide_q;
    assign READ_PINS      = pins_q;
    assign PRESCALER_CLR  = pclr_q;
    assign DUMMY_CYCLE    = flush_q;
    assign FLUSH_PREFETCH = flush_q;
    assign PHASE          = phase_q;

    // byte class routes by d
    a_dest_route: assert property (@(posedge MCLK) disable iff (SRST) // RL4
        WREG_WE |-> !DEST_FREG) else $error("wreg write with d set");
    a_no_write_dummy: assert property (@(posedge MCLK) disable iff (SRST) // RL13
        DUMMY_CYCLE |-> !WREG_WE && !FREG_WE && !PRESCALER_CLR) else $error("write in dummy cycle");
    a_phase_wrap: assert property (@(posedge MCLK) disable iff (SRST) // RL10
        (PHASE == 2'h3) |=> (PHASE == 2'h0)) else $error("phase did not wrap after four");
    // the first edge after release still shows the reset phase twice, so it starts no attempt
    a_phase_step: assert property (@(posedge MCLK) disable iff (SRST) // RL10
        !$past(SRST) && (PHASE != 2'h3) |=> (PHASE == $past(PHASE) + 2'h1)) else $error("phase skipped");
    a_lit_narrow: assert property (@(posedge MCLK) disable iff (SRST) // RL7
        !LIT_WIDE |-> (LITERAL[10:8] == 3'h0)) else $error("narrow literal has high bits");
    a_wide_class: assert property (@(posedge MCLK) disable iff (SRST) // RL2
        LIT_WIDE |-> (INSTR_CLASS == 2'(IWD_CLASS_LITCTL))) else $error("wide literal outside class");
    a_dummy_single: assert property (@(posedge MCLK) disable iff (SRST) // RL9
        $rose(DUMMY_CYCLE) |-> DUMMY_CYCLE [*4] ##1 !DUMMY_CYCLE) else $error("dummy cycle length");
    a_pclr_timer: assert property (@(posedge MCLK) disable iff (SRST) // RL12
        PRESCALER_CLR |-> (FILE_ADDR == TIMER_ADDR) && DEST_FREG) else $error("prescaler clear elsewhere");
    a_write_once: assert property (@(posedge MCLK) disable iff (SRST) // RL9
        FREG_WE |=> !FREG_WE [*3]) else $error("more than one write per cycle");

    c_wreg:  cover property (@(posedge MCLK) disable iff (SRST) WREG_WE);
    c_freg:  cover property (@(posedge MCLK) disable iff (SRST) FREG_WE);
    c_dummy: cover property (@(posedge MCLK) disable iff (SRST) $rose(DUMMY_CYCLE));
    c_pclr:  cover property (@(posedge MCLK) disable iff (SRST) PRESCALER_CLR);
endmodule

// file: design/iwd_pkg.sv
/*
 * iwd_pkg: constants shared by the instruction word decoder and its
 * four-phase cycle sequencer.
 * assumes: single clock MCLK, synchronous active-high reset SRST.
 */
package iwd_pkg;
    localparam int IWD_WORD_W     = 14;
    localparam int IWD_FADDR_W    = 7;
    localparam int IWD_BIT_W      = 3;
    localparam int IWD_LIT8_W     = 8;
    localparam int IWD_LIT11_W    = 11;
    localparam int IWD_PHASES     = 4;
    // field positions inside the word
    localparam int IWD_CLASS_LSB  = 12;
    localparam int IWD_DEST_POS   = 7;
    localparam int IWD_BIT_LSB    = 7;
    localparam int IWD_BOP_LSB    = 10;
    localparam int IWD_BYTEOP_LSB = 8;
    // class codes in the top two bits
    localparam logic [1:0] IWD_CLS_BYTE = 2'h0;
    localparam logic [1:0] IWD_CLS_BIT  = 2'h1;
    localparam logic [1:0] IWD_CLS_JUMP = 2'h2;
    localparam logic [1:0] IWD_CLS_LIT  = 2'h3;
    // byte-class sub opcodes: the two skips, then movwf and clrf
    localparam logic [3:0] IWD_OP_DECFSZ = 4'hB;
    localparam logic [3:0] IWD_OP_INCFSZ = 4'hF;
    localparam logic [3:0] IWD_OP_MOVWF  = 4'h0;
    localparam logic [3:0] IWD_OP_CLRF   = 4'h1;
    // bit-class sub opcodes
    localparam logic [1:0] IWD_BOP_TSTC  = 2'h2;
    localparam logic [1:0] IWD_BOP_TSTS  = 2'h3;
    // program-flow returns: full words, then the retlw code in bits 11:8
    localparam logic [13:0] IWD_W_RETURN = 14'h0008;
    localparam logic [13:0] IWD_W_RETFIE = 14'h0009;
    localparam logic [3:0]  IWD_LIT_RETLW = 4'h4;
    // reset values
    localparam logic [1:0]  IWD_PHASE_RST = 2'h0;
    localparam logic [13:0] IWD_WORD_RST  = 14'h0000;
    // destination encodings
    localparam logic IWD_DEST_WREG = 1'b0;
    localparam logic IWD_DEST_FREG = 1'b1;

    typedef enum logic [1:0] {IWD_CLASS_BYTE, IWD_CLASS_BIT, IWD_CLASS_LITCTL} iwd_class_e;
endpackage

// file: design/iwd_phase_seq.sv
/*
 * iwd_phase_seq: four-phase counter, one instruction cycle per four MCLK.
 * assumes: MCLK is the oscillator, SRST synchronous active high.
 */
`timescale 1ns/1ps
module iwd_phase_seq
    import iwd_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    output logic [1:0]      phase,
    output logic            cycle_end
);
    logic [1:0] phase_q;
    logic [1:0] phase_d;

    assign phase_d   = phase_q + 2'h1; // RL10
    assign phase     = phase_q;
    assign cycle_end = (phase_q == 2'(IWD_PHASES - 1)); // RL10

    always_ff @(posedge clk) begin
        if (srst) begin
            phase_q <= IWD_PHASE_RST;
        end else begin
            phase_q <= phase_d;
        end
    end
endmodule

// file: tb/iwd_pmem.sv
/*
 * iwd_pmem: program memory model feeding one fetched word per push.
 * assumes: decoder takes the word on every fourth MCLK edge counted from
 * the first edge after SRST falls.
 */
`timescale 1ns/1ps
module iwd_pmem (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        push,
    input  wire logic [13:0] word_in,
    output logic      [13:0] word
);
    logic [1:0]  cnt_q;
    logic        pend_q;
    logic [13:0] hold_q;
    // word changes only mid-cycle, so it stands across the edge that takes it;
    // an unused slot carries a no-op rather than repeating the last word
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q  <= 2'h0;
            pend_q <= 1'b0;
            hold_q <= 14'h0000;
            word   <= 14'h0000;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            if (push) begin
                pend_q <= 1'b1;
                hold_q <= word_in;
            end
            if (cnt_q == 2'h2) begin
                word <= pend_q ? hold_q : 14'h0000;
                if (!push) begin
                    pend_q <= 1'b0;
                end
            end
        end
    end
endmodule

// file: tb/tb.sv
/*
 * tb: directed bench for the instruction word decoder.
 * assumes: pulses are one clock wide and a taken test or flow change
 * yields one dummy cycle; the memory model supplies each word.
 */
`timescale 1ns/1ps
`define CHK(a,e) begin num_checks++; if ((a)!==(e)) begin fails++; $display("[FAIL] t=%0t got=%h exp=%h",$time,a,e); end end
module tb;
    logic        MCLK = 1'b0, SRST = 1'b1, SKIP_TAKEN = 1'b0, PRESCALER_ON_TIMER = 1'b0, push = 1'b0;
    logic [13:0] pm_word = 14'h0000, INSTR_WORD;
    logic [1:0]  INSTR_CLASS, PHASE, pp = 2'h0;
    logic [6:0]  FILE_ADDR;
    logic [2:0]  BIT_NUM;
    logic [10:0] LITERAL;
    logic        DEST_FREG, WREG_WE, FREG_WE, LIT_WIDE, READ_PINS, PRESCALER_CLR, DUMMY_CYCLE, FLUSH_PREFETCH;
    logic        mon = 1'b0, dp = 1'b0;
    int          fails = 0, num_checks = 0, cw = 0, cf = 0, cp = 0, cd = 0, perr = 0;

    always #10 MCLK = ~MCLK;

    iwd_pmem pm (.clk(MCLK), .srst(SRST), .push(push), .word_in(pm_word), .word(INSTR_WORD));
    iwd_decoder #(.TIMER_ADDR(7'h01), .PORT_LO(7'h05), .PORT_HI(7'h09)) uut (.MCLK, .SRST, .INSTR_WORD,
        .SKIP_TAKEN, .PRESCALER_ON_TIMER, .INSTR_CLASS, .FILE_ADDR, .DEST_FREG, .WREG_WE, .FREG_WE,
        .BIT_NUM, .LITERAL, .LIT_WIDE, .READ_PINS, .PRESCALER_CLR, .DUMMY_CYCLE, .FLUSH_PREFETCH, .PHASE);

    // pulse counters; phase must step by one every clock
    always @(posedge MCLK) begin
        if (mon) begin
            cw += WREG_WE;
            cf += FREG_WE;
            cp += PRESCALER_CLR;
            cd += (DUMMY_CYCLE && !dp);
            if (PHASE !== pp + 2'h1 || FLUSH_PREFETCH !== DUMMY_CYCLE || (DUMMY_CYCLE && (WREG_WE || FREG_WE))) perr++;
        end
        pp = PHASE;
        dp = DUMMY_CYCLE;
    end

    function automatic logic [25:0] expf(input logic [13:0] w);
        logic j;
        j = (w[13:12] == 2'h2);
        return {w[13] ? 2'h2 : {1'b0, w[12]}, w[6:0], w[7], w[9:7], j ? w[10:0] : {3'h0, w[7:0]}, j,
                !w[13] && w[6:0] >= 7'h05 && w[6:0] <= 7'h09};
    endfunction

    function automatic logic [25:0] got();
        return {INSTR_CLASS, FILE_ADDR, DEST_FREG, BIT_NUM, LITERAL, LIT_WIDE, READ_PINS};
    endfunction

    // skip input rises only once the word is decoded: earlier, the cycle before it would see a taken test;
    // it is held past the word's phase 3, then dropped before the next slot samples it
    task automatic issue(input logic [13:0] w, input logic sk, input int nw, nf, np, dm);
        int w0, f0, p0, d0, i;
        w0 = cw;
        f0 = cf;
        p0 = cp;
        d0 = cd;
        pm_word = w;
        push = 1'b1;
        @(posedge MCLK);
        #1 push = 1'b0;
        for (i = 0; i < 16 && got() !== expf(w); i++) begin
            @(posedge MCLK);
            #1;
        end
        SKIP_TAKEN = sk;
        `CHK(got(), expf(w))
        repeat (4) @(posedge MCLK);
        #1 SKIP_TAKEN = 1'b0;
        repeat (16) @(posedge MCLK);
        #1;
        `CHK(cw - w0, nw)
        `CHK(cf - f0, nf)
        `CHK(cp - p0, np)
        `CHK(cd - d0, dm)
    endtask

    task automatic t_byte;
        issue(14'h077F, 1'b0, 1, 0, 0, 0);
        issue(14'h0780, 1'b0, 0, 1, 0, 0);
        issue(14'h0BA0, 1'b0, 0, 1, 0, 0);
        issue(14'h0BA0, 1'b1, 0, 1, 0, 1);
        $display("byte class done");
    endtask

    task automatic t_bit;
        issue(14'h17B3, 1'b0, 0, 1, 0, 0);
        issue(14'h1811, 1'b0, 0, 0, 0, 0);
        issue(14'h1C11, 1'b1, 0, 0, 0, 1);
        $display("bit class done");
    endtask

    task automatic t_lit;
        issue(14'h30A5, 1'b0, 0, 0, 0, 0);
        issue(14'h33A5, 1'b0, 0, 0, 0, 0);
        issue(14'h3442, 1'b0, 0, 0, 0, 1);
        issue(14'h2DA3, 1'b0, 0, 0, 0, 1);
        issue(14'h2123, 1'b0, 0, 0, 0, 1);
        issue(14'h0008, 1'b0, 0, 0, 0, 1);
        issue(14'h0009, 1'b0, 0, 0, 0, 1);
        $display("literal and flow done");
    endtask

    task automatic t_port;
        PRESCALER_ON_TIMER = 1'b1;
        issue(14'h0886, 1'b0, 0, 1, 0, 0);
        issue(14'h0181, 1'b0, 0, 1, 1, 0);
        issue(14'h0182, 1'b0, 0, 1, 0, 0);
        PRESCALER_ON_TIMER = 1'b0;
        issue(14'h0181, 1'b0, 0, 1, 0, 0);
        $display("port and timer done");
    endtask

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge MCLK);
        #1 SRST = 1'b0;
        repeat (8) @(posedge MCLK);
        #1 mon = 1'b1;
        t_byte();
        t_bit();
        t_lit();
        t_port();
        `CHK(perr, 0)
        end_sim();
    end

    // whole run needs well under 1000 clocks
    initial begin
        #200000;
        fails++;
        end_sim();
    end
endmodule
